// ### pdb_core.sv
// device-side sideband, exit, read crossing and packet timing logic
// assumes all link clocks arrive as plain inputs sampled by clk
`timescale 1ns/100ps
`default_nettype none
module pdb_core #(
  parameter int CHAIN_BITS = pdb_pkg::CHAIN_W
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       sideband_clk,
  input  wire logic                       sideband_cmd,
  input  wire logic                       serial_chain_port_a_in,
  output logic                            serial_chain_port_a_out,
  output logic                            serial_chain_port_a_oe,
  input  wire logic                       serial_chain_port_b_in,
  output logic                            serial_chain_port_b_out,
  output logic                            serial_chain_port_b_oe,
  input  wire logic                       receive_clock_pair,
  input  wire logic                       transmit_clock_pair,
  input  wire logic [pdb_pkg::ADDR_W-1:0] data_lane_a,
  input  wire logic                       broadcast_exit_select,
  input  wire logic [pdb_pkg::ADDR_W-1:0] device_addr,
  input  wire logic                       powerdown_state,
  input  wire logic                       init_done,
  input  wire logic [1:0]                 delay_option,
  input  wire logic [pdb_pkg::CAC_W-1:0]  cac_cycles,
  input  wire logic                       read_cmd,
  input  wire logic                       column_cmd,
  input  wire logic                       packet_start,
  input  wire logic                       serial_read_active,
  input  wire logic                       chain_load,
  input  wire logic [CHAIN_BITS-1:0]      chain_word,
  output logic                            cmd_odd,
  output logic                            cmd_even,
  output logic                            cmd_valid,
  output logic                            chain_rx_bit,
  output logic                            chain_rx_valid,
  output logic                            chain_tx_busy,
  output logic                            exit_go,
  output logic                            read_data_valid,
  output logic                            core_column,
  output logic                            packet_busy,
  output logic                            packet_done
);
  import pdb_pkg::*;

  logic [SYNC_W-1:0]  sync_in;
  logic [SYNC_W-1:0]  meta_reg;
  logic [SYNC_W-1:0]  sync_reg;
  logic [SYNC_W-1:0]  prev_reg;
  logic               sb_rise;
  logic               sb_fall;
  logic               rx_tick;
  logic               tx_tick;
  logic [ADDR_W-1:0]  lane_s;
  logic               cmd_odd_reg;
  logic               cmd_even_reg;
  logic               cmd_valid_reg;
  logic               chain_rx_bit_reg;
  logic               chain_rx_valid_reg;
  logic [CHAIN_BITS-1:0] tx_shift_reg;
  logic [3:0]         tx_count_reg;
  logic               tx_busy_reg;
  pdb_exit_t          exit_state_reg;
  logic               exit_go_reg;
  logic [1:0]         delay_sel_reg;
  logic [CAC_W-1:0]   cac_reg;
  logic               init_seen_reg;
  logic               rd_pend_reg;
  logic [LINE_W-1:0]  line_reg;
  logic [CAC_W-1:0]   tap;
  logic               xfer_pend_reg;
  logic               rd_valid_reg;
  logic               col_pend_reg;
  logic [1:0]         col_lag_reg;
  logic               core_col_reg;
  logic [2:0]         pkt_count_reg;
  logic               pkt_busy_reg;
  logic               pkt_done_reg;

  // picks the delay line tap for the chosen option
  function automatic logic [CAC_W-1:0] pick_tap(
    input logic [CAC_W-1:0] cac,
    input logic [1:0]       sel
  );
    logic [CAC_W-1:0] t;
    t = cac;
    if (sel == PDB_DLY_SHORT) begin
      t = cac - 4'h1;
    end else if (sel == PDB_DLY_LONG) begin
      t = cac + 4'h1;
    end
    return t;
  endfunction

  // clamps the programmed access delay into range
  function automatic logic [CAC_W-1:0] clamp_cac(
    input logic [CAC_W-1:0] v
  );
    logic [CAC_W-1:0] r;
    r = v;
    if (v < CAC_MIN) begin
      r = CAC_MIN;
    end else if (v > CAC_MAX) begin
      r = CAC_MAX;
    end
    return r;
  endfunction

  // sideband inputs are high true, no inversion
  assign sync_in = {data_lane_a, serial_chain_port_b_in, transmit_clock_pair,
                    receive_clock_pair, serial_chain_port_a_in, sideband_cmd,
                    sideband_clk};

  // two-stage synchronisers, one per lane
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= sync_in[gi];
          sync_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= sync_reg[gi];
        end
      end
    end
  endgenerate

  assign sb_rise = sync_reg[IX_SBCLK] & ~prev_reg[IX_SBCLK];
  assign sb_fall = ~sync_reg[IX_SBCLK] & prev_reg[IX_SBCLK];
  assign rx_tick = sync_reg[IX_RXCLK] & ~prev_reg[IX_RXCLK];
  assign tx_tick = sync_reg[IX_TXCLK] & ~prev_reg[IX_TXCLK];
  assign lane_s  = sync_reg[IX_LANE +: ADDR_W];

  // command line: odd bit on rise, even bit on fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_odd_reg   <= 1'b0;
      cmd_even_reg  <= 1'b0;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= sb_fall;
      if (sb_rise) begin
        cmd_odd_reg <= sync_reg[IX_CMD];
      end
      if (sb_fall) begin
        cmd_even_reg <= sync_reg[IX_CMD];
      end
    end
  end

  // chain input sampled once per period on fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_rx_bit_reg   <= 1'b0;
      chain_rx_valid_reg <= 1'b0;
    end else begin
      chain_rx_valid_reg <= sb_fall;
      if (sb_fall) begin
        chain_rx_bit_reg <= sync_reg[IX_CHA];
      end
    end
  end

  // returned serial word shifted out from falling edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_shift_reg <= '0;
      tx_count_reg <= 4'h0;
      tx_busy_reg  <= 1'b0;
    end else if (!tx_busy_reg && chain_load) begin
      tx_shift_reg <= chain_word;
      tx_count_reg <= 4'h0;
      tx_busy_reg  <= 1'b1;
    end else if (tx_busy_reg && sb_fall) begin
      tx_shift_reg <= {tx_shift_reg[CHAIN_BITS-2:0], 1'b0};
      tx_count_reg <= tx_count_reg + 4'h1;
      if (tx_count_reg == CHAIN_LAST) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  // forward path a to b, return path b to a for reads
  assign serial_chain_port_b_out = serial_chain_port_a_in;
  assign serial_chain_port_b_oe  = ~serial_read_active;
  assign serial_chain_port_a_out = tx_busy_reg ?
                                   tx_shift_reg[CHAIN_BITS-1] :
                                   serial_chain_port_b_in;
  assign serial_chain_port_a_oe  = tx_busy_reg | serial_read_active;

  // nap or powerdown exit, broadcast or directed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_state_reg <= PDB_EX_IDLE;
      exit_go_reg    <= 1'b0;
    end else begin
      exit_go_reg <= 1'b0;
      case (exit_state_reg)
        PDB_EX_IDLE: begin
          if (powerdown_state && sb_rise && sync_reg[IX_CMD]) begin
            exit_state_reg <= PDB_EX_WAIT_ADDR;
          end
        end
        PDB_EX_WAIT_ADDR: begin
          if (!powerdown_state) begin
            exit_state_reg <= PDB_EX_IDLE;
          end else if (sb_rise) begin
            if (broadcast_exit_select) begin
              exit_go_reg    <= 1'b1;
              exit_state_reg <= PDB_EX_DONE;
            end else if (lane_s == device_addr) begin
              exit_go_reg    <= 1'b1;
              exit_state_reg <= PDB_EX_DONE;
            end else begin
              exit_state_reg <= PDB_EX_IDLE;
            end
          end
        end
        PDB_EX_DONE: begin
          if (!powerdown_state) begin
            exit_state_reg <= PDB_EX_IDLE;
          end
        end
        default: begin
          exit_state_reg <= PDB_EX_IDLE;
        end
      endcase
    end
  end

  // delay option and access delay latched once at init
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delay_sel_reg <= PDB_DLY_NOMINAL;
      cac_reg       <= CAC_MIN;
      init_seen_reg <= 1'b0;
    end else if (init_done && !init_seen_reg) begin
      delay_sel_reg <= delay_option;
      cac_reg       <= clamp_cac(cac_cycles);
      init_seen_reg <= 1'b1;
    end
  end

  assign tap = pick_tap(cac_reg, delay_sel_reg);

  // read command delay line in receive clock cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_reg <= 1'b0;
      line_reg    <= '0;
    end else begin
      if (rx_tick) begin
        line_reg    <= {line_reg[LINE_W-2:0], rd_pend_reg};
        rd_pend_reg <= read_cmd;
      end else if (read_cmd) begin
        rd_pend_reg <= 1'b1;
      end
    end
  end

  // hand over to the transmit clock at its next edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xfer_pend_reg <= 1'b0;
      rd_valid_reg  <= 1'b0;
    end else begin
      rd_valid_reg <= tx_tick & xfer_pend_reg;
      if (rx_tick && line_reg[tap - 4'h1]) begin
        xfer_pend_reg <= 1'b1;
      end else if (tx_tick) begin
        xfer_pend_reg <= 1'b0;
      end
    end
  end

  // core column strobe trails the channel by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      col_pend_reg <= 1'b0;
      col_lag_reg  <= 2'h0;
      core_col_reg <= 1'b0;
    end else begin
      core_col_reg <= 1'b0;
      if (column_cmd) begin
        col_pend_reg <= 1'b1;
      end else if (rx_tick && col_pend_reg) begin
        col_pend_reg <= 1'b0;
      end
      if (rx_tick) begin
        if (col_pend_reg) begin
          col_lag_reg <= CORE_LAG;
        end else if (col_lag_reg != 2'h0) begin
          col_lag_reg <= col_lag_reg - 2'h1;
          if (col_lag_reg == 2'h1) begin
            core_col_reg <= 1'b1;
          end
        end
      end
    end
  end

  // each packet holds the link for four channel cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pkt_count_reg <= 3'h0;
      pkt_busy_reg  <= 1'b0;
      pkt_done_reg  <= 1'b0;
    end else begin
      pkt_done_reg <= 1'b0;
      if (!pkt_busy_reg && packet_start) begin
        pkt_busy_reg  <= 1'b1;
        pkt_count_reg <= 3'h0;
      end else if (pkt_busy_reg && rx_tick) begin
        pkt_count_reg <= pkt_count_reg + 3'h1;
        if (pkt_count_reg == PKT_LEN - 3'h1) begin
          pkt_busy_reg <= 1'b0;
          pkt_done_reg <= 1'b1;
        end
      end
    end
  end

  assign cmd_odd         = cmd_odd_reg;
  assign cmd_even        = cmd_even_reg;
  assign cmd_valid       = cmd_valid_reg;
  assign chain_rx_bit    = chain_rx_bit_reg;
  assign chain_rx_valid  = chain_rx_valid_reg;
  assign chain_tx_busy   = tx_busy_reg;
  assign exit_go         = exit_go_reg;
  assign read_data_valid = rd_valid_reg;
  assign core_column     = core_col_reg;
  assign packet_busy     = pkt_busy_reg;
  assign packet_done     = pkt_done_reg;

  a_cmd_even_edge: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_valid_reg |-> $past(sb_fall))
    else $error("even command bit without falling edge");

  a_cmd_odd_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(sb_rise) |-> $stable(cmd_odd_reg))
    else $error("odd command bit changed off rising edge");

  a_chain_rx_fall: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(chain_rx_bit_reg) |-> $past(sb_fall))
    else $error("chain input sampled off falling edge");

  a_chain_tx_fall: assert property (@(posedge clk) disable iff (!arst_n)
    ($past(tx_busy_reg) && tx_busy_reg && $changed(tx_count_reg))
      |-> $past(sb_fall))
    else $error("chain bit launched off falling edge");

  a_forward_path: assert property (@(posedge clk) disable iff (!arst_n)
    serial_chain_port_b_out == serial_chain_port_a_in)
    else $error("chain forward path broken");

  a_exit_bcast: assert property (@(posedge clk) disable iff (!arst_n)
    (exit_state_reg == PDB_EX_WAIT_ADDR && powerdown_state && sb_rise &&
     broadcast_exit_select) |=> exit_go_reg)
    else $error("broadcast exit not taken");

  a_exit_directed: assert property (@(posedge clk) disable iff (!arst_n)
    exit_go_reg |-> ($past(broadcast_exit_select) ||
                     $past(lane_s) == $past(device_addr)))
    else $error("directed exit without address match");

  a_delay_fixed: assert property (@(posedge clk) disable iff (!arst_n)
    $past(init_seen_reg) |-> ($stable(delay_sel_reg) && $stable(cac_reg)))
    else $error("read delay option changed after init");

  a_cac_range: assert property (@(posedge clk) disable iff (!arst_n)
    cac_reg >= CAC_MIN && cac_reg <= CAC_MAX)
    else $error("access delay out of range");

  a_read_cross: assert property (@(posedge clk) disable iff (!arst_n)
    rd_valid_reg |-> $past(tx_tick) && !xfer_pend_reg)
    else $error("read data not launched on transmit edge");

  a_packet_len: assert property (@(posedge clk) disable iff (!arst_n)
    pkt_done_reg |-> $past(pkt_count_reg) == PKT_LEN - 3'h1)
    else $error("packet length not four cycles");
endmodule
`default_nettype wire

// ### pdb_pkg.sv
// constants shared by the packet dram bank timing block
// assumes a single 200 MHz core clock sampling all link clocks
package pdb_pkg;
  localparam int          ADDR_W      = 6;
  localparam int          CAC_W       = 4;
  localparam int          SYNC_W      = 12;
  localparam logic [3:0]  CAC_MIN     = 4'h8;
  localparam logic [3:0]  CAC_MAX     = 4'hC;
  localparam int          LINE_W      = 14;
  localparam logic [2:0]  PKT_LEN     = 3'h4;
  localparam logic [1:0]  CORE_LAG    = 2'h1;
  localparam int          CHAIN_W     = 8;
  localparam logic [3:0]  CHAIN_LAST  = 4'h7;
  // synchroniser lane positions
  localparam int          IX_SBCLK    = 0;
  localparam int          IX_CMD      = 1;
  localparam int          IX_CHA      = 2;
  localparam int          IX_RXCLK    = 3;
  localparam int          IX_TXCLK    = 4;
  localparam int          IX_LANE     = 6;
  localparam int          IX_CHB      = 5;
  typedef enum logic [1:0] {
    PDB_DLY_NOMINAL,
    PDB_DLY_SHORT,
    PDB_DLY_LONG
  } pdb_dly_t;
  typedef enum logic [1:0] {
    PDB_EX_IDLE,
    PDB_EX_WAIT_ADDR,
    PDB_EX_DONE
  } pdb_exit_t;
endpackage

// ### pdb_ctrl_model.sv
// controller model driving sideband frames towards the device
// assumes the bench raises go once per frame and waits for busy low
`timescale 1ns/100ps
`default_nettype none
module pdb_ctrl_model (
  input  wire logic       go,
  input  wire logic [7:0] odd_bits,
  input  wire logic [7:0] even_bits,
  input  wire logic [7:0] chain_bits,
  input  wire logic [5:0] lane_addr,
  input  wire logic       dev_chain_out,
  output logic            sideband_clk,
  output logic            sideband_cmd,
  output logic            chain_out,
  output logic [5:0]      lane,
  output logic            busy,
  output logic [7:0]      got_word
);
  initial begin
    sideband_clk = 1'b0;
    sideband_cmd = 1'b0;
    chain_out = 1'b0;
    lane = 6'h00;
    busy = 1'b0;
    got_word = 8'h00;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (int i = 0; i < 8; i++) begin
        sideband_cmd = odd_bits[i];
        lane = lane_addr;
        #31 sideband_clk = 1'b1;
        #31 sideband_cmd = even_bits[i];
        chain_out = chain_bits[i];
        #31 sideband_clk = 1'b0;
        got_word = {got_word[6:0], dev_chain_out};
        #32;
      end
      // clock stands still; released lines show inverted values
      sideband_cmd = ~sideband_cmd;
      chain_out = ~chain_out;
      lane = ~lane;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb_packet_dram_bank_timing.sv
// self-checking bench for the packet dram bank timing core
// assumes pdb_pkg, pdb_core and pdb_ctrl_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_packet_dram_bank_timing;
  import pdb_pkg::*;
  logic              clk, arst_n, sideband_clk, sideband_cmd;
  logic              serial_chain_port_a_in, serial_chain_port_a_out;
  logic              serial_chain_port_a_oe, serial_chain_port_b_in;
  logic              serial_chain_port_b_out, serial_chain_port_b_oe;
  logic              receive_clock_pair, transmit_clock_pair, read_cmd;
  logic              broadcast_exit_select, powerdown_state, init_done;
  logic              column_cmd, packet_start, serial_read_active;
  logic              chain_load, cmd_odd, cmd_even, cmd_valid, chain_rx_bit;
  logic              chain_rx_valid, chain_tx_busy, exit_go, core_column;
  logic              read_data_valid, packet_busy, packet_done, go, busy;
  logic [ADDR_W-1:0] data_lane_a, device_addr, lane_addr;
  logic [1:0]        delay_option;
  logic [CAC_W-1:0]  cac_cycles;
  logic [7:0]        chain_word, odd_bits, even_bits, chain_bits, got_word;
  logic [31:0]       seed;
  int                err_count, n_compared, ph, rises, n_exit;
  logic              q_odd[$], q_even[$], q_chain[$];
  int                cfg_c[5] = '{8, 12, 8, 12, 15};
  int                cfg_o[5] = '{1, 2, 0, 3, 2};

  pdb_core u_pdb_core (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .sideband_clk            (sideband_clk),
    .sideband_cmd            (sideband_cmd),
    .serial_chain_port_a_in  (serial_chain_port_a_in),
    .serial_chain_port_a_out (serial_chain_port_a_out),
    .serial_chain_port_a_oe  (serial_chain_port_a_oe),
    .serial_chain_port_b_in  (serial_chain_port_b_in),
    .serial_chain_port_b_out (serial_chain_port_b_out),
    .serial_chain_port_b_oe  (serial_chain_port_b_oe),
    .receive_clock_pair      (receive_clock_pair),
    .transmit_clock_pair     (transmit_clock_pair),
    .data_lane_a             (data_lane_a),
    .broadcast_exit_select   (broadcast_exit_select),
    .device_addr             (device_addr),
    .powerdown_state         (powerdown_state),
    .init_done               (init_done),
    .delay_option            (delay_option),
    .cac_cycles              (cac_cycles),
    .read_cmd                (read_cmd),
    .column_cmd              (column_cmd),
    .packet_start            (packet_start),
    .serial_read_active      (serial_read_active),
    .chain_load              (chain_load),
    .chain_word              (chain_word),
    .cmd_odd                 (cmd_odd),
    .cmd_even                (cmd_even),
    .cmd_valid               (cmd_valid),
    .chain_rx_bit            (chain_rx_bit),
    .chain_rx_valid          (chain_rx_valid),
    .chain_tx_busy           (chain_tx_busy),
    .exit_go                 (exit_go),
    .read_data_valid         (read_data_valid),
    .core_column             (core_column),
    .packet_busy             (packet_busy),
    .packet_done             (packet_done)
  );
  pdb_ctrl_model u_pdb_ctrl_model (
    .go            (go),
    .odd_bits      (odd_bits),
    .even_bits     (even_bits),
    .chain_bits    (chain_bits),
    .lane_addr     (lane_addr),
    .dev_chain_out (serial_chain_port_a_out),
    .sideband_clk  (sideband_clk),
    .sideband_cmd  (sideband_cmd),
    .chain_out     (serial_chain_port_a_in),
    .lane          (data_lane_a),
    .busy          (busy),
    .got_word      (got_word)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int exp_tap(input int c, input int o);
    int t;
    t = (c < int'(CAC_MIN)) ? int'(CAC_MIN) : c;
    t = (t > int'(CAC_MAX)) ? int'(CAC_MAX) : t;
    if (o == 1) t = t - 1;
    if (o == 2) t = t + 1;
    return t;
  endfunction

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    err_count++;
    $display("BAD %0t: wait ran out", $time);
    summarize();
  endtask

  // one clk: sample pulses, then advance the channel clocks
  task automatic step();
    @(negedge clk);
    if (cmd_valid === 1'b1) begin
      q_odd.push_back(cmd_odd);
      q_even.push_back(cmd_even);
    end
    if (chain_rx_valid === 1'b1) q_chain.push_back(chain_rx_bit);
    if (exit_go === 1'b1) n_exit++;
    ph = (ph + 1) % 8;
    receive_clock_pair = (ph < 4);
    transmit_clock_pair = (ph >= 2 && ph < 6);
    if (ph == 0) rises++;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (6) step();
    arst_n = 1'b1;
    repeat (2) step();
  endtask

  task automatic align();
    while (ph != 7) step();
    step();
    rises = 1;
  endtask

  task automatic wait_pulse(input int sel);
    int k;
    for (k = 0; k < 600; k++) begin
      step();
      if ((sel == 0 && read_data_valid === 1'b1) ||
          (sel == 1 && core_column === 1'b1) ||
          (sel == 2 && packet_done === 1'b1)) break;
    end
    if (k == 600) tmo();
  endtask

  task automatic frame(input logic [7:0] o, input logic [7:0] e);
    int k;
    odd_bits = o;
    even_bits = e;
    go = 1'b1;
    step();
    go = 1'b0;
    for (k = 0; k < 400 && busy === 1'b1; k++) step();
    if (busy !== 1'b0) tmo();
    repeat (8) step();
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    int         i, k, c, o;
    logic [7:0] ob, eb;
    seed = 32'h0000AB9E;
    {arst_n, go, read_cmd, column_cmd, packet_start, chain_load} = 6'h00;
    {broadcast_exit_select, powerdown_state, init_done} = 3'h0;
    {serial_read_active, serial_chain_port_b_in} = 2'h0;
    {receive_clock_pair, transmit_clock_pair} = 2'h0;
    {odd_bits, even_bits, chain_bits, chain_word} = 32'h0;
    delay_option = 2'h0;
    cac_cycles = 4'h8;
    device_addr = 6'(rnd());
    lane_addr = device_addr;
    err_count = 0;
    n_compared = 0;
    ph = 0;
    rises = 0;
    n_exit = 0;
    for (i = 0; i < 9; i++) begin
      c = (i < 5) ? cfg_c[i] : 8 + int'(rnd() % 5);
      o = (i < 5) ? cfg_o[i] : int'(rnd() % 3);
      init_done = 1'b0;
      cac_cycles = 4'(c);
      delay_option = 2'(o);
      do_reset();
      init_done = 1'b1;
      repeat (3) step();
      cac_cycles = 4'(8 + rnd() % 5);
      delay_option = 2'(rnd() % 3);
      align();
      read_cmd = 1'b1;
      step();
      read_cmd = 1'b0;
      wait_pulse(0);
      check(rises, exp_tap(c, o) + 1);
    end
    repeat (8 * 9) step();
    align();
    column_cmd = 1'b1;
    step();
    column_cmd = 1'b0;
    wait_pulse(1);
    check(rises, int'(CORE_LAG) + 1);
    for (i = 0; i < 2; i++) begin
      // bench keeps the controller's row spacing timers
      if (i > 0) repeat (8 * 28) step();
      align();
      packet_start = 1'b1;
      step();
      packet_start = 1'b0;
      check(packet_busy, 1'b1);
      wait_pulse(2);
      check(rises, int'(PKT_LEN));
    end
    for (i = 0; i < 8; i++) begin
      step();
      serial_read_active = 1'(rnd());
      serial_chain_port_b_in = 1'(rnd());
      #1;
      check(serial_chain_port_b_out, serial_chain_port_a_in);
      check(serial_chain_port_b_oe, !serial_read_active);
      check(serial_chain_port_a_out, serial_chain_port_b_in);
      check(serial_chain_port_a_oe, serial_read_active);
    end
    serial_read_active = 1'b0;
    for (i = 0; i < 3; i++) begin
      chain_word = 8'(rnd());
      chain_bits = 8'(rnd());
      chain_load = 1'b1;
      step();
      chain_load = 1'b0;
      step();
      check(chain_tx_busy, 1'b1);
      check(serial_chain_port_a_oe, 1'b1);
      q_odd.delete();
      q_even.delete();
      q_chain.delete();
      n_exit = 0;
      ob = 8'(rnd());
      eb = 8'(rnd());
      frame(ob, eb);
      check(got_word, chain_word);
      check(chain_tx_busy, 1'b0);
      check(n_exit, 0);
      check(q_even.size(), 8);
      for (k = 0; k < 8; k++) begin
        check(q_odd[k], ob[k]);
        check(q_even[k], eb[k]);
        check(q_chain[k], chain_bits[k]);
      end
    end
    for (i = 0; i < 6; i++) begin
      broadcast_exit_select = (i % 3 == 0);
      powerdown_state = 1'b0;
      step();
      powerdown_state = 1'b1;
      lane_addr = (i % 3 == 1) ? device_addr
                               : device_addr ^ 6'(1 + rnd() % 63);
      n_exit = 0;
      frame(8'h01, 8'(rnd()));
      check(n_exit, (i % 3 != 2) ? 1 : 0);
    end
    powerdown_state = 1'b0;
    step();
    summarize();
  end
endmodule
`default_nettype wire
